// ===== ospuc_pkg.sv
// Shared constants and types for the oscillator stabilization, PLL and USB clock block
package ospuc_pkg;

   // ------------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_STAB_STATUS = 16'hFFA3; // Stabilization status, read only
   localparam logic [15:0] ADDR_STAB_SELECT = 16'hFFA4; // Stabilization wait select
   localparam logic [15:0] ADDR_PLL_CTRL    = 16'hFFA6; // PLL control
   localparam logic [15:0] ADDR_USB_CLK     = 16'hFFA7; // USB clock gate

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [2:0] RST_STAB_SELECT = 3'h5; // Longest wait, 2^16 periods
   localparam logic       RST_PLL_HALT    = 1'b1; // PLL stopped
   localparam logic       RST_PLL_RATIO   = 1'b0; // Divide by 2, multiply by 8
   localparam logic       RST_USB_ON      = 1'b0; // USB clock stopped
   localparam logic [4:0] RST_STAB_STATUS = 5'h00; // No wait elapsed yet

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int POS_PLL_HALT  = 0; // PLL control bit 0
   localparam int POS_PLL_RATIO = 1; // PLL control bit 1
   localparam int POS_USB_ON    = 7; // USB clock gate bit 7
   localparam int STAB_SEL_W    = 3; // Width of the wait select code
   localparam int STAB_BITS     = 5; // Number of stabilization status bits

   // ------------------------------------------------------------------
   // Wait selection codes and thresholds
   // ------------------------------------------------------------------
   localparam logic [2:0] STAB_CODE_MIN = 3'h1; // Shortest legal code
   localparam logic [2:0] STAB_CODE_MAX = 3'h5; // Longest legal code
   localparam int         STAB_CNT_W    = 17;   // Counter reaches 2^16 inclusive

   // Exponent of the wait in crystal periods for legal code k (1..5)
   function automatic int stab_exp(input int k);
      case (k)
         1:       stab_exp = 11;
         2:       stab_exp = 13;
         3:       stab_exp = 14;
         4:       stab_exp = 15;
         default: stab_exp = 16;
      endcase
   endfunction : stab_exp

   // ------------------------------------------------------------------
   // Stop and wake sequence states, Gray coded along RUN-STOP-WAIT
   // ------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      OSPUC_RUN  = 2'b00,
      OSPUC_STOP = 2'b01,
      OSPUC_WAIT = 2'b11
   } ospuc_state_t;

   // Prescaler default depth
   localparam int PRESC_STAGES = 4; // Main clock /2 .. /16

endpackage : ospuc_pkg

// ===== ospuc_prescaler.sv
// Prescaler producing divided clock enables from the main system clock
`timescale 1ns/10ps
module ospuc_prescaler
#(
   parameter int STAGES = ospuc_pkg::PRESC_STAGES
)
(
   // Clock and control
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // Divider run request
   input  wire logic              run,
   // Divided enables, bit i pulses once per 2^(i+1) cycles
   output logic [STAGES-1:0]      divTick
);
   import ospuc_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   if (STAGES < 1 || STAGES > 16)
   begin : g_chk
      $error("Prescaler stage count out of range");
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed
   {
      logic [STAGES-1:0] cnt;  // Divide counter, held at zero while run is low
      logic [STAGES-1:0] tick; // Registered enables
   } ospuc_presc_st_t;

   ospuc_presc_st_t st_reg;  // Current state
   ospuc_presc_st_t st_next; // Next state

   logic [STAGES-1:0] cntInc; // Counter plus one
   logic [STAGES-1:0] stageHit; // Low bits all ones per stage

   assign cntInc = st_reg.cnt + {{(STAGES-1){1'b0}}, 1'b1};

   // One comparator per stage: a stage wraps when its low bits are all ones
   for (genvar i = 0; i < STAGES; i++)
   begin : g_stage
      assign stageHit[i] = &st_reg.cnt[i:0];
   end

   // Next state; counter parks at zero while the CPU is not on the main clock
   always_comb
   begin
      st_next = st_reg;
      if (run)
      begin
         st_next.cnt  = cntInc; // see [R21]
         st_next.tick = stageHit;
      end
      else
      begin
         st_next.cnt  = '0;
         st_next.tick = '0;
      end
   end

   // State register with synchronous reset and clock enable
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st_reg <= '0;
      else if (ce)
         st_reg <= st_next;
   end

   assign divTick = st_reg.tick;

endmodule : ospuc_prescaler

// ===== ospuc_clock_ctrl.sv
// Stabilization wait, PLL control, USB clock gate and internal oscillator control
//
// Contract
// [R1] Crystal CPU held until selected wait elapses
// [R2] Three-bit select, codes 1..5 pick 2^11..2^16
// [R3] Select register resets to 05H
// [R4] Select register takes byte writes only
// [R5] Status counts no further than selected wait
// [R6] Software polls status up to selected wait
// [R7] Software sets select before STOP
// [R8] Software leaves select alone during wait
// [R9] Counting starts only once crystal oscillates
// [R10] PLL control resets to 01H
// [R11] PLL control bit 0 halts PLL
// [R12] Ratio 0: /2 x8, ratio 1: /4 x12
// [R13] 12 or 16 MHz gives 48 MHz
// [R14] Software order: halt, ratio, select, run
// [R15] USB gate resets 00H, bit 7 supplies
// [R16] Software gates USB off across STOP
// [R17] Internal fast oscillator runs after reset
// [R18] Slow clock feeds watchdog and timer only
// [R19] Option decides if slow oscillator stoppable
// [R20] Slow oscillator starts, clocks enabled watchdog
// [R21] Prescaler divides main system clock
// [R22] Status bits set in order, stay set; here a shorter select also clears bits already set
// [R23] Status clears on reset, STOP, crystal stop
// [R24] Counter counts crystal periods from start
`timescale 1ns/10ps
module ospuc_clock_ctrl
#(
   parameter int CNT_W    = ospuc_pkg::STAB_CNT_W,
   parameter int PRESC_N  = ospuc_pkg::PRESC_STAGES
)
(
   // Clock, reset and freeze
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   ce,
   // CPU memory access
   input  wire logic [15:0]            addr,
   input  wire logic                   wrEn,
   input  wire logic                   rdEn,
   input  wire logic                   bitOp,
   input  wire logic [2:0]             bitSel,
   input  wire logic [7:0]             wrData,
   output logic [7:0]                  rdData,
   // Standby events and crystal status
   input  wire logic                   stopExec,
   input  wire logic                   stopRelease,
   input  wire logic                   crystalRunning,
   input  wire logic                   crystalTick,
   input  wire logic                   crystal_osc_stop,
   input  wire logic                   cpuOnCrystal,
   input  wire logic                   hs_clock_select,
   input  wire logic                   mainClkToCpu,
   // Internal oscillator requests and option settings
   input  wire logic                   hsOscOffReq,
   input  wire logic                   lsOscOffReq,
   input  wire logic                   lsStopAllowed,
   input  wire logic                   wdtEnabled,
   // Clock control outputs
   output logic                        cpuHold,
   output logic [ospuc_pkg::STAB_BITS-1:0] stab_wait_status,
   output logic                        pllEnable,
   output logic                        pllDiv4,
   output logic                        pllMul12,
   output logic                        usbClkGateOn,
   output logic                        hsOscRun,
   output logic                        lsOscRun,
   output logic                        wdtClkRun,
   output logic                        tmh1ClkRun,
   output logic [PRESC_N-1:0]          prescTick
);
   import ospuc_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   if (CNT_W < STAB_CNT_W || CNT_W > 31)
   begin : g_chk
      $error("Stabilization counter too narrow for 2^16 periods");
   end

   // ------------------------------------------------------------------
   // State record
   // ------------------------------------------------------------------
   typedef struct packed
   {
      ospuc_state_t         mode;       // Stop and wake sequence
      logic [CNT_W-1:0]     cnt;        // Crystal periods since start
      logic [STAB_BITS-1:0] stat;       // Elapsed-wait flags
      logic [2:0]           selCode;    // Wait select code
      logic                 pllHalt;    // PLL stop bit
      logic                 pllRatio;   // PLL ratio select
      logic                 usbOn;      // USB supply bit
      logic [7:0]           rdData;     // Registered read answer
      logic                 hold;       // CPU held after wake
      logic                 pllEn;      // PLL running
      logic                 div4;       // Input divider by 4
      logic                 mul12;      // Multiplier 12
      logic                 hsRun;      // Fast oscillator running
      logic                 lsRun;      // Slow oscillator running
      logic                 wdtRun;     // Watchdog clock supplied
      logic                 tmh1Run;    // Timer H1 clock supplied
   } ospuc_st_t;

   ospuc_st_t st_reg;  // Current state
   ospuc_st_t st_next; // Next state

   // ------------------------------------------------------------------
   // Thresholds, one per status bit
   // ------------------------------------------------------------------
   logic [STAB_BITS-1:0] reached;     // Count passed each threshold
   logic [STAB_BITS-1:0] allowedMask; // Thresholds within the selected wait
   logic [CNT_W-1:0]     waitLimit;   // Count for the selected wait
   logic                 waitDone;    // Selected wait elapsed

   // Status bit STAB_BITS-1-j belongs to code j+1
   for (genvar j = 0; j < STAB_BITS; j++)
   begin : g_thr
      localparam logic [CNT_W-1:0] THR = CNT_W'(1) << stab_exp(j + 1);
      assign reached[STAB_BITS-1-j]     = (st_reg.cnt >= THR);      // see [R24]
      assign allowedMask[STAB_BITS-1-j] = (st_reg.selCode >= 3'(j + 1)); // see [R5]
   end

   // Limit of the selected code; codes are kept legal by the write filter
   always_comb
   begin
      waitLimit = CNT_W'(1) << stab_exp(int'(st_reg.selCode)); // see [R2]
   end

   assign waitDone = (st_reg.cnt >= waitLimit);

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   logic selByteWr; // Byte write to the select register
   logic pllWr;     // Any write to PLL control
   logic usbWr;     // Any write to the USB gate
   logic legalCode; // Written code within 1..5

   assign selByteWr = wrEn && !bitOp && (addr == ADDR_STAB_SELECT); // see [R4]
   assign pllWr     = wrEn && (addr == ADDR_PLL_CTRL);
   assign usbWr     = wrEn && (addr == ADDR_USB_CLK);
   assign legalCode = (wrData[2:0] >= STAB_CODE_MIN) && (wrData[2:0] <= STAB_CODE_MAX);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;

      // Stop and wake sequence
      case (st_reg.mode)
         OSPUC_RUN:
         begin
            if (stopExec)
               st_next.mode = OSPUC_STOP;
         end
         OSPUC_STOP:
         begin
            if (stopRelease)
            begin
               st_next.mode = OSPUC_WAIT;
               st_next.hold = cpuOnCrystal; // see [R1]
            end
         end
         OSPUC_WAIT:
         begin
            // Wait ends once the selected count is reached
            if (waitDone)
            begin
               st_next.mode = OSPUC_RUN;
               st_next.hold = 1'b0; // see [R1]
            end
         end
         default:
         begin
            st_next.mode = OSPUC_RUN;
            st_next.hold = 1'b0;
         end
      endcase

      // Counter: only real crystal periods count, saturating at the wait
      if (stopExec || crystal_osc_stop)
         st_next.cnt = '0;
      else if (crystalRunning && crystalTick && st_reg.mode != OSPUC_STOP && !waitDone)
         st_next.cnt = st_reg.cnt + CNT_W'(1); // see [R9] see [R24]

      // Status flags: sticky, limited, cleared by STOP or crystal stop
      if (stopExec || crystal_osc_stop)
         st_next.stat = RST_STAB_STATUS; // see [R23]
      else
         // Masked each cycle, so a shorter select also trims bits already set
         st_next.stat = (st_reg.stat | reached) & allowedMask; // see [R22] see [R5]

      // Select register: byte writes only, prohibited codes dropped
      if (selByteWr && legalCode)
         st_next.selCode = wrData[2:0]; // see [R2] see [R4]

      // PLL control, byte or bit access
      if (pllWr && !bitOp)
      begin
         st_next.pllHalt  = wrData[POS_PLL_HALT];
         st_next.pllRatio = wrData[POS_PLL_RATIO];
      end
      else if (pllWr && bitOp && bitSel == 3'(POS_PLL_HALT))
         st_next.pllHalt = wrData[0];
      else if (pllWr && bitOp && bitSel == 3'(POS_PLL_RATIO))
         st_next.pllRatio = wrData[0];

      // USB gate, byte or bit access
      if (usbWr && !bitOp)
         st_next.usbOn = wrData[POS_USB_ON];
      else if (usbWr && bitOp && bitSel == 3'(POS_USB_ON))
         st_next.usbOn = wrData[0];

      // Read answer, one cycle after the request; unmapped reads give zero
      if (rdEn)
      begin
         case (addr)
            ADDR_STAB_STATUS: st_next.rdData = {3'h0, st_reg.stat};
            ADDR_STAB_SELECT: st_next.rdData = {5'h00, st_reg.selCode};
            ADDR_PLL_CTRL:    st_next.rdData = {6'h00, st_reg.pllRatio, st_reg.pllHalt};
            ADDR_USB_CLK:     st_next.rdData = {st_reg.usbOn, 7'h00};
            default:          st_next.rdData = 8'h00;
         endcase
      end

      // PLL drive; prohibited without the high-speed clock select, so kept off then
      st_next.pllEn = !st_next.pllHalt && hs_clock_select; // see [R11] see [R12]
      st_next.div4  = st_next.pllRatio;  // see [R12] see [R13]
      st_next.mul12 = st_next.pllRatio;  // see [R12] see [R13]

      // Internal oscillators: fast one on unless turned off
      st_next.hsRun   = !hsOscOffReq; // see [R17]
      st_next.lsRun   = !(lsStopAllowed && lsOscOffReq); // see [R19]
      // Slow clock only reaches watchdog and timer H1, never the CPU
      st_next.wdtRun  = st_next.lsRun && wdtEnabled; // see [R20] see [R18]
      st_next.tmh1Run = st_next.lsRun; // see [R18]
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st_reg         <= '0;
         st_reg.mode    <= OSPUC_RUN;
         st_reg.stat    <= RST_STAB_STATUS; // see [R23]
         st_reg.selCode <= RST_STAB_SELECT; // see [R3]
         st_reg.pllHalt <= RST_PLL_HALT;    // see [R10]
         st_reg.pllRatio <= RST_PLL_RATIO;  // see [R10]
         st_reg.usbOn   <= RST_USB_ON;      // see [R15]
         st_reg.hsRun   <= 1'b1;            // see [R17]
         st_reg.lsRun   <= 1'b1;            // see [R20]
      end
      else if (ce)
         st_reg <= st_next;
   end

   // ------------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------------
   ospuc_prescaler #(.STAGES(PRESC_N)) u_presc
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .run     (mainClkToCpu),
      .divTick (prescTick)
   );

   // ------------------------------------------------------------------
   // Outputs, all from the state register
   // ------------------------------------------------------------------
   assign rdData           = st_reg.rdData;
   assign cpuHold          = st_reg.hold;
   assign stab_wait_status = st_reg.stat;
   assign pllEnable        = st_reg.pllEn;
   assign pllDiv4          = st_reg.div4;
   assign pllMul12         = st_reg.mul12;
   assign usbClkGateOn     = st_reg.usbOn; // see [R15]
   assign hsOscRun         = st_reg.hsRun;
   assign lsOscRun         = st_reg.lsRun;
   assign wdtClkRun        = st_reg.wdtRun;
   assign tmh1ClkRun       = st_reg.tmh1Run;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_SEL_RESET: assert property ($past(rst_n) == 1'b0 |-> st_reg.selCode == 3'h5) // see [R3]
      else $error("Select register not 05H after reset");
   AST_PLL_CONTROL_RESET: assert property ($past(rst_n) == 1'b0 |-> !pllEnable && !pllDiv4) // see [R10]
      else $error("PLL not stopped after reset");
   AST_USB_RESET: assert property ($past(rst_n) == 1'b0 |-> !usbClkGateOn) // see [R15]
      else $error("USB clock supplied after reset");
   AST_SEL_NO_BIT: assert property (ce && wrEn && bitOp && addr == ADDR_STAB_SELECT // see [R4]
      |=> $stable(st_reg.selCode))
      else $error("Bit write changed select register");
   AST_STAT_LIMIT: assert property ((stab_wait_status & ~allowedMask) == '0 // see [R5]
      || $changed(st_reg.selCode) || $past(ce && selByteWr))
      else $error("Status bit beyond selected wait");
   AST_STAT_CLEAR: assert property (ce && stopExec |=> stab_wait_status == 5'h00) // see [R23]
      else $error("Status not cleared by STOP");
   AST_STAT_STICKY: assert property (ce && stab_wait_status[4] && !stopExec // see [R22]
      && !crystal_osc_stop |=> stab_wait_status[4])
      else $error("Elapsed flag dropped");
   AST_HOLD_RELEASE: assert property (ce && cpuHold && waitDone // see [R1]
      |=> !cpuHold ##1 !cpuHold)
      else $error("CPU hold not released at end of wait");
   AST_NO_EARLY_COUNT: assert property (ce && !crystalRunning && !stopExec // see [R9]
      && !crystal_osc_stop |=> $stable(st_reg.cnt))
      else $error("Counted before crystal started");
   AST_PLL_HALT_BIT: assert property (ce && wrEn && !bitOp && addr == ADDR_PLL_CTRL // see [R11]
      && wrData[0] |=> !pllEnable)
      else $error("PLL running with halt bit set");
   AST_USB_GATE_BIT: assert property (ce && wrEn && !bitOp && addr == ADDR_USB_CLK // see [R15]
      |=> usbClkGateOn == $past(wrData[7]))
      else $error("USB gate does not follow bit 7");

   COV_WAKE_HOLD: cover property (cpuHold ##[1:1000] !cpuHold);
   COV_STOP_WAKE: cover property (st_reg.mode == OSPUC_STOP ##1 st_reg.mode == OSPUC_WAIT);
   COV_PLL_X12: cover property (pllEnable && pllMul12);
   COV_ALL_ELAPSED: cover property (stab_wait_status == 5'h1F);

endmodule : ospuc_clock_ctrl

// ===== ospuc_testbench.sv
// Self-checking testbench for the stabilization, PLL and USB clock block
`timescale 1ns/10ps
module testbench;
   import ospuc_pkg::*;

   // ---------------------------------------------------------------
   // Stimulus, observed outputs and bookkeeping
   // ---------------------------------------------------------------
   logic        clk = 0, rst_n = 0, ce = 1, wrEn = 0, rdEn = 0, bitOp = 0;
   logic [15:0] addr = '0;
   logic [2:0]  bitSel = '0;
   logic [7:0]  wrData = '0, rdData, rnd = 8'h33;
   logic        stopExec = 0, stopRelease = 0, crystalRunning = 0, crystalTick = 0;
   logic        crystal_osc_stop = 0, cpuOnCrystal = 1, hs_clock_select = 1;
   logic        mainClkToCpu = 0, hsOscOffReq = 0, lsOscOffReq = 0;
   logic        lsStopAllowed = 0, wdtEnabled = 1;
   logic        cpuHold, pllEnable, pllDiv4, pllMul12, usbClkGateOn;
   logic        hsOscRun, lsOscRun, wdtClkRun, tmh1ClkRun;
   logic [4:0]  stab_wait_status;
   logic [3:0]  prescTick;
   logic [15:0] rndAddr[4] = '{ADDR_STAB_SELECT, ADDR_USB_CLK, 16'hFFA5, ADDR_STAB_STATUS};
   int          num_errors = 0, total_checks = 0, cycles = 0, n, m;
   int          mdl[int];   // Register image kept by the bench, unmapped keys absent

   ospuc_clock_ctrl ospuc_clock_ctrl_i (.clk, .rst_n, .ce, .addr, .wrEn, .rdEn, .bitOp,
      .bitSel, .wrData, .rdData, .stopExec, .stopRelease, .crystalRunning, .crystalTick,
      .crystal_osc_stop, .cpuOnCrystal, .hs_clock_select, .mainClkToCpu, .hsOscOffReq,
      .lsOscOffReq, .lsStopAllowed, .wdtEnabled, .cpuHold, .stab_wait_status, .pllEnable,
      .pllDiv4, .pllMul12, .usbClkGateOn, .hsOscRun, .lsOscRun, .wdtClkRun, .tmh1ClkRun,
      .prescTick);

   // ---------------------------------------------------------------
   // Clock and hang guard
   // ---------------------------------------------------------------
   initial
   begin
      forever #50 clk = ~clk;
   end

   // Longest run is the 2^11 wake wait at one tick per two cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 12000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr

   // Pass edges, then land a fixed delay after the last one
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #10;
   endtask : tick

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One write; the image ignores read-only, unmapped and refused writes
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b,
                     input logic [2:0] s);
      addr = a;
      wrData = d;
      bitOp = b;
      bitSel = s;
      wrEn = 1;
      tick(1);
      wrEn = 0;
      bitOp = 0;
      // One idle edge, so a following call never re-raises the strobe at once
      tick(1);
      if (mdl.exists(a) && a != ADDR_STAB_STATUS
          && !(a == ADDR_STAB_SELECT && (b || d < 1 || d > 5)))
      begin
         if (b)
            mdl[a][s] = d[0];
         else
            mdl[a] = d;
      end
      mdl[ADDR_PLL_CTRL] = mdl[ADDR_PLL_CTRL] & 3;
      mdl[ADDR_USB_CLK] = mdl[ADDR_USB_CLK] & 8'h80;
   endtask : wr

   // One read, answer compared while it stands, before the next read
   task automatic rdchk(input logic [15:0] a);
      addr = a;
      rdEn = 1;
      tick(1);
      rdEn = 0;
      tick(1);
      chk(rdData, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
   endtask : rdchk

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      mdl[ADDR_STAB_STATUS] = 0;
      mdl[ADDR_STAB_SELECT] = 5;
      mdl[ADDR_PLL_CTRL] = 1;
      mdl[ADDR_USB_CLK] = 0;
      tick(3);
      rst_n = 1;
      // Reset image, unmapped FFA5 included
      for (int a = 16'hFFA3; a <= 16'hFFA7; a++)
         rdchk(16'(a));
      chk({hsOscRun, lsOscRun}, 8'h03);
      // Random byte and bit writes; refused codes and bit writes to the select keep old value
      for (int i = 0; i < 24; i++)
      begin
         rnd = lfsr(rnd);
         n = rnd[1:0];
         m = lfsr(rnd);
         wr(rndAddr[n], n == 0 ? 8'(m & 7) : 8'(m), rnd[7], rnd[6:4]);
         rdchk(rndAddr[n]);
         chk(usbClkGateOn, 8'(mdl[ADDR_USB_CLK] >> 7));
      end
      // PLL set up in the required order for each ratio and select
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_PLL_CTRL, 8'(2 * i[0] + 1), 0, 0);
         hs_clock_select = i[1];
         wr(ADDR_PLL_CTRL, 8'h00, 1, 0);
         tick(1);
         chk({pllEnable, pllDiv4, pllMul12}, {5'h0, i[1], i[0], i[0]});
         rdchk(ADDR_PLL_CTRL);
      end
      // Internal oscillators against off requests and option settings
      for (int i = 0; i < 16; i++)
      begin
         {wdtEnabled, lsStopAllowed, lsOscOffReq, hsOscOffReq} = 4'(i);
         tick(2);
         chk({hsOscRun, lsOscRun}, {6'h0, !i[0], !(i[1] && i[2])});
         chk(wdtClkRun, 8'(!(i[1] && i[2]) && i[3]));
         chk(tmh1ClkRun, 8'(!(i[1] && i[2])));
      end
      // Prescaler idle, then running from the main clock
      for (int r = 0; r < 2; r++)
      begin
         mainClkToCpu = r[0];
         tick(2);
         n = 0;
         m = 0;
         repeat (64)
         begin
            tick(1);
            n += prescTick[0];
            m += prescTick[3];
         end
         chk(8'(n), 8'(32 * r));
         chk(8'(m), 8'(4 * r));
      end
      // Clock enable low freezes the divider; an odd count would flip bit 0
      ce = 0;
      n = prescTick;
      tick(3);
      chk(prescTick, 8'(n));
      ce = 1;
      // Stop and wake on the crystal with the shortest wait, USB clock gated off first
      wr(ADDR_USB_CLK, 8'h00, 0, 0);
      wr(ADDR_STAB_SELECT, 8'h01, 0, 0);
      stopExec = 1;
      tick(1);
      stopExec = 0;
      tick(1);
      stopRelease = 1;
      tick(1);
      stopRelease = 0;
      tick(1);
      chk({cpuHold, stab_wait_status}, 8'h20);
      // Ticks before oscillation starts must not count
      repeat (100)
      begin
         crystalTick = ~crystalTick;
         tick(1);
      end
      crystalTick = 0;
      crystalRunning = 1;
      chk(cpuHold, 8'h01);
      n = 0;
      // Select left untouched for the whole wait
      while (cpuHold === 1'b1 && n < 3000)
      begin
         crystalTick = ~crystalTick;
         n += crystalTick;
         tick(1);
      end
      crystalTick = 0;
      chk(8'(n >= 2048 && n <= 2050), 8'h01);
      tick(2);
      chk(stab_wait_status, 8'h10);
      mdl[ADDR_STAB_STATUS] = 8'h10;
      rdchk(ADDR_STAB_STATUS);
      crystal_osc_stop = 1;
      tick(2);
      mdl[ADDR_STAB_STATUS] = 0;
      rdchk(ADDR_STAB_STATUS);
      // Stop and wake on the internal clock: the CPU is never held
      cpuOnCrystal = 0;
      stopExec = 1;
      tick(1);
      stopExec = 0;
      tick(1);
      stopRelease = 1;
      tick(1);
      stopRelease = 0;
      tick(1);
      chk({cpuHold, stab_wait_status}, 8'h00);
      report_and_stop();
   end

endmodule : testbench
